// ### hdl/lcem_pkg.sv
`default_nettype none

package lcem_pkg;

   // Register map, byte addresses on a 12-bit APB address.
   localparam logic [11:0] OFF_CTRL    = 12'h000;
   localparam logic [11:0] OFF_CNT_LO  = 12'h004;
   localparam logic [11:0] OFF_CNT_HI  = 12'h008;
   localparam logic [11:0] OFF_STATUS  = 12'h00c;

   // Control register fields.
   localparam int          CTRL_EV_LSB  = 0;
   localparam int          CTRL_UM_LSB  = 8;
   localparam int          CTRL_CLR_BIT = 17;
   localparam int          CTRL_EN_BIT  = 22;
   localparam logic [7:0]  EV_RST       = 8'h00;
   localparam logic [7:0]  UM_RST       = 8'h00;

   // Status register fields.
   localparam int          STAT_EMPTY_LSB  = 0;
   localparam int          STAT_SHARED_LSB = 8;

   // Event codes.
   localparam logic [7:0]  EV_RES_USE   = 8'h5c;
   localparam logic [7:0]  EV_RES_EMPTY = 8'h5e;
   localparam logic [7:0]  EV_WB_PEND   = 8'h7d;
   localparam logic [7:0]  EV_WB_CMP    = 8'h7e;
   localparam logic [7:0]  EV_PREFETCH  = 8'h61;

   // Occupancy compare mask layout: three bits per network, top bit both-nonzero.
   localparam int          UM_CMP_STRIDE  = 4;
   localparam int          UM_BOTH_NZ_BIT = 7;

   // Message classes of the second virtual network, in unit-mask bit order.
   localparam int          CLASS_N   = 6;
   localparam int          CLS_W     = 3;
   localparam logic [2:0]  CLS_HOME  = 3'h0;
   localparam logic [2:0]  CLS_SNOOP = 3'h1;
   localparam logic [2:0]  CLS_RSPA  = 3'h2;
   localparam logic [2:0]  CLS_RSPD  = 3'h3;
   localparam logic [2:0]  CLS_COH   = 3'h4;
   localparam logic [2:0]  CLS_NCB   = 3'h5;

   // Widths and reset values.
   localparam int          CNT_W      = 48;
   localparam int          CNT_HI_W   = 16;
   localparam int          FLIT_W     = 4;
   localparam int          SHARED_W   = 7;
   localparam int          RES_W      = 2;
   localparam int          OCC_W      = 6;
   localparam int          VN_N       = 2;
   localparam int          PEND_N     = 8;
   localparam int          PF_N       = 7;
   localparam logic [6:0]  SHARED_RST = 7'h40;
   localparam logic [1:0]  RES_RST    = 2'h2;

   typedef struct packed {
      logic              valid;
      logic [CLS_W-1:0]  cls;
      logic [FLIT_W-1:0] flits;
   } lcem_req_s;

   typedef struct packed {
      logic                valid;
      logic [SHARED_W-1:0] count;
   } lcem_ret_s;

   typedef struct packed {
      logic             valid;
      logic             granted;
      logic             reserved;
      logic [CLS_W-1:0] cls;
   } lcem_grant_s;

   typedef struct packed {
      logic [VN_N-1:0][OCC_W-1:0] rtOcc;
      logic [VN_N-1:0][OCC_W-1:0] localOcc;
   } lcem_wbocc_s;

endpackage : lcem_pkg

`default_nettype wire

// ### hdl/lcem_credit_pool.sv
`default_nettype none

module lcem_credit_pool (
   // Clock and reset.
   input  wire logic                                    ref_clk,
   input  wire logic                                    sys_rst,
   // Offers and credit returns.
   input  wire lcem_pkg::lcem_req_s                     creditReq,
   input  wire lcem_pkg::lcem_ret_s                     sharedRet,
   input  wire logic [lcem_pkg::CLASS_N-1:0]            reservedRet,
   // Results.
   output var  lcem_pkg::lcem_grant_s                   creditGrant,
   output var  logic [lcem_pkg::CLASS_N-1:0]            reservedEmpty,
   output var  logic [lcem_pkg::SHARED_W-1:0]           sharedLevel
);

   typedef struct packed {
      logic [lcem_pkg::SHARED_W-1:0]                        shared;
      logic [lcem_pkg::CLASS_N-1:0][lcem_pkg::RES_W-1:0]    res;
      logic [lcem_pkg::CLASS_N-1:0]                         empty;
      lcem_pkg::lcem_grant_s                                grant;
   } lcem_pool_s;

   lcem_pool_s state_r;
   lcem_pool_s state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.grant = '0;
      if (sharedRet.valid) begin
         state_nxt.shared = state_r.shared + sharedRet.count;
      end
      for (int c = 0; c < lcem_pkg::CLASS_N; c++) begin
         if (reservedRet[c]) begin
            state_nxt.res[c] = state_r.res[c] + lcem_pkg::RES_W'(1);
         end
      end
      if (creditReq.valid) begin
         state_nxt.grant.valid = 1'b1;
         state_nxt.grant.cls   = creditReq.cls;
         // Shared pool first, one credit per remote flit buffer.
         if (lcem_pkg::SHARED_W'(creditReq.flits) <= state_nxt.shared) begin //RULE_02
            state_nxt.grant.granted = 1'b1;
            state_nxt.shared = state_nxt.shared - lcem_pkg::SHARED_W'(creditReq.flits); //RULE_03
         end else if (int'(creditReq.cls) < lcem_pkg::CLASS_N) begin
            // Each class owns its own reserved entries, so one starved class
            // cannot block another.
            if (state_nxt.res[creditReq.cls] != '0) begin //RULE_05
               state_nxt.grant.granted  = 1'b1;
               state_nxt.grant.reserved = 1'b1;
               // A single reserved credit covers all buffers of the transfer.
               state_nxt.res[creditReq.cls] = state_nxt.res[creditReq.cls] //RULE_04
                                            - lcem_pkg::RES_W'(1);
            end
         end
      end
      for (int c = 0; c < lcem_pkg::CLASS_N; c++) begin
         state_nxt.empty[c] = (state_nxt.res[c] == '0);
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r.shared <= lcem_pkg::SHARED_RST;
         state_r.res    <= {lcem_pkg::CLASS_N{lcem_pkg::RES_RST}};
         state_r.empty  <= '0;
         state_r.grant  <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign creditGrant   = state_r.grant;
   assign reservedEmpty = state_r.empty;
   assign sharedLevel   = state_r.shared;

endmodule : lcem_credit_pool

`default_nettype wire

// ### hdl/lcem_monitor.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`default_nettype none

// What this block does
// RULE_01: Count reserved-pool credit uses under code 0x5c.
// RULE_02: Try shared pool first, reserved as fallback.
// RULE_03: Shared pool spends one credit per flit.
// RULE_04: Reserved pool spends one credit per transfer.
// RULE_05: Reserved entries kept separately per message class.
// RULE_06: Mask bits pick message classes for credit events.
// RULE_07: Count cycles reserved credits empty under 0x5e.
// RULE_08: Prefetch mask bit0 counts arrivals.
// RULE_09: Prefetch mask bit1 counts bypass path.
// RULE_10: Prefetch bits2,3 count arbitration requests and losses.
// RULE_11: Prefetch bit4 counts non-bypass flit slotting.
// RULE_12: Prefetch bit5 counts age drops.
// RULE_13: Prefetch bit6 counts queue-full overwrite drops.
// RULE_14: Enabled mask conditions combine as logical OR.
// RULE_15: Compare writeback occupancies, optional both-nonzero qualifier.
// RULE_16: Count outstanding writeback kinds per network.
module lcem_monitor (
   // Clock and reset.
   input  wire logic                                 ref_clk,
   input  wire logic                                 sys_rst,
   // APB slave.
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [11:0]                          paddr,
   input  wire logic [31:0]                          pwdata,
   output var  logic [31:0]                          prdata,
   output var  logic                                 pready,
   output var  logic                                 pslverr,
   // Link credit offers and returns.
   input  wire lcem_pkg::lcem_req_s                  creditReq,
   input  wire lcem_pkg::lcem_ret_s                  sharedRet,
   input  wire logic [lcem_pkg::CLASS_N-1:0]         reservedRet,
   output var  lcem_pkg::lcem_grant_s                creditGrant,
   output var  logic [lcem_pkg::CLASS_N-1:0]         reservedEmpty,
   // Writeback and prefetch event sources.
   input  wire lcem_pkg::lcem_wbocc_s                wbOcc,
   input  wire logic [lcem_pkg::PEND_N-1:0]          wbPending,
   input  wire logic [lcem_pkg::PF_N-1:0]            prefetchEv
);

   typedef struct packed {
      logic [7:0]                 evCode;
      logic [7:0]                 umask;
      logic                       enable;
      logic [lcem_pkg::CNT_W-1:0] count;
      logic [31:0]                prdata;
      logic                       pready;
      logic                       pslverr;
   } lcem_mon_s;

   lcem_mon_s                      state_r;
   lcem_mon_s                      state_nxt;
   lcem_pkg::lcem_grant_s          grantInt;
   logic [lcem_pkg::CLASS_N-1:0]   emptyInt;
   logic [lcem_pkg::SHARED_W-1:0]  sharedLevel;
   logic                           useHit;
   logic                           emptyHit;
   logic                           cmpHit;
   logic                           pendHit;
   logic                           pfHit;
   logic                           eventHit;

   lcem_credit_pool u_pool (
      .ref_clk       (ref_clk),
      .sys_rst       (sys_rst),
      .creditReq     (creditReq),
      .sharedRet     (sharedRet),
      .reservedRet   (reservedRet),
      .creditGrant   (grantInt),
      .reservedEmpty (emptyInt),
      .sharedLevel   (sharedLevel)
   );

   // Event qualification from the selected code and its unit mask.
   always_comb begin
      logic [lcem_pkg::CLASS_N-1:0] clsSel;
      logic                         gt;
      logic                         eq;
      logic                         lt;
      logic                         bothNz;
      logic                         qual;
      clsSel = '0;
      gt     = 1'b0;
      eq     = 1'b0;
      lt     = 1'b0;
      bothNz = 1'b0;
      qual   = 1'b0;
      cmpHit = 1'b0;
      // Mask bit n selects class n for both credit events.
      if (int'(grantInt.cls) < lcem_pkg::CLASS_N) begin
         clsSel[grantInt.cls] = 1'b1; //RULE_06
      end
      useHit   = grantInt.valid && grantInt.granted && grantInt.reserved //RULE_01
               && ((clsSel & state_r.umask[lcem_pkg::CLASS_N-1:0]) != '0);
      emptyHit = (emptyInt & state_r.umask[lcem_pkg::CLASS_N-1:0]) != '0; //RULE_07
      for (int v = 0; v < lcem_pkg::VN_N; v++) begin
         gt     = wbOcc.rtOcc[v] > wbOcc.localOcc[v]; //RULE_15
         eq     = wbOcc.rtOcc[v] == wbOcc.localOcc[v];
         lt     = wbOcc.rtOcc[v] < wbOcc.localOcc[v];
         bothNz = (wbOcc.rtOcc[v] != '0) && (wbOcc.localOcc[v] != '0);
         qual   = !state_r.umask[lcem_pkg::UM_BOTH_NZ_BIT] || bothNz;
         cmpHit = cmpHit || (qual
                  && ((state_r.umask[v*lcem_pkg::UM_CMP_STRIDE]     && gt)
                  ||  (state_r.umask[v*lcem_pkg::UM_CMP_STRIDE + 1] && eq)
                  ||  (state_r.umask[v*lcem_pkg::UM_CMP_STRIDE + 2] && lt)));
      end
      pendHit = (wbPending & state_r.umask) != '0; //RULE_16
      // Bits 0..6 are arrival, bypass, request, loss, slotted, aged, overwrite.
      pfHit   = (prefetchEv[0] && state_r.umask[0]) //RULE_08
             || (prefetchEv[1] && state_r.umask[1]) //RULE_09
             || ((prefetchEv[3:2] & state_r.umask[3:2]) != '0) //RULE_10
             || (prefetchEv[4] && state_r.umask[4]) //RULE_11
             || (prefetchEv[5] && state_r.umask[5]) //RULE_12
             || (prefetchEv[6] && state_r.umask[6]); //RULE_13
      unique case (state_r.evCode)
         lcem_pkg::EV_RES_USE:   eventHit = useHit;
         lcem_pkg::EV_RES_EMPTY: eventHit = emptyHit;
         lcem_pkg::EV_WB_CMP:    eventHit = cmpHit;
         lcem_pkg::EV_WB_PEND:   eventHit = pendHit;
         lcem_pkg::EV_PREFETCH:  eventHit = pfHit; //RULE_14
         default:                eventHit = 1'b0;
      endcase
   end

   // Register file and counter.
   always_comb begin
      logic setup;
      logic access;
      setup  = psel && !penable;
      access = psel && penable && state_r.pready;
      state_nxt = state_r;
      state_nxt.pready  = 1'b0;
      state_nxt.pslverr = 1'b0;
      if (state_r.enable && eventHit) begin
         state_nxt.count = state_r.count + lcem_pkg::CNT_W'(1);
      end
      // Access is decoded in the setup cycle; the answer comes one cycle later.
      if (setup) begin
         state_nxt.pready = 1'b1;
         state_nxt.prdata = '0;
         unique case (paddr)
            lcem_pkg::OFF_CTRL: begin
               state_nxt.prdata[lcem_pkg::CTRL_EV_LSB +: 8] = state_r.evCode;
               state_nxt.prdata[lcem_pkg::CTRL_UM_LSB +: 8] = state_r.umask;
               state_nxt.prdata[lcem_pkg::CTRL_EN_BIT]      = state_r.enable;
            end
            lcem_pkg::OFF_CNT_LO: begin
               state_nxt.prdata = state_r.count[31:0];
            end
            lcem_pkg::OFF_CNT_HI: begin
               state_nxt.prdata[lcem_pkg::CNT_HI_W-1:0] = state_r.count[lcem_pkg::CNT_W-1:32];
            end
            lcem_pkg::OFF_STATUS: begin
               state_nxt.prdata[lcem_pkg::STAT_EMPTY_LSB +: lcem_pkg::CLASS_N] = emptyInt;
               state_nxt.prdata[lcem_pkg::STAT_SHARED_LSB +: lcem_pkg::SHARED_W] = sharedLevel;
            end
            default: begin
               state_nxt.pslverr = 1'b1;
            end
         endcase
      end
      // A software write to a counter half overrides a same-cycle increment in that half only.
      if (access && pwrite && !state_r.pslverr) begin
         unique case (paddr)
            lcem_pkg::OFF_CTRL: begin
               state_nxt.evCode = pwdata[lcem_pkg::CTRL_EV_LSB +: 8];
               state_nxt.umask  = pwdata[lcem_pkg::CTRL_UM_LSB +: 8];
               state_nxt.enable = pwdata[lcem_pkg::CTRL_EN_BIT];
               if (pwdata[lcem_pkg::CTRL_CLR_BIT]) begin
                  state_nxt.count = '0;
               end
            end
            lcem_pkg::OFF_CNT_LO: begin
               state_nxt.count[31:0] = pwdata;
            end
            lcem_pkg::OFF_CNT_HI: begin
               state_nxt.count[lcem_pkg::CNT_W-1:32] = pwdata[lcem_pkg::CNT_HI_W-1:0];
            end
            default: begin
               state_nxt.count = state_nxt.count;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r.evCode  <= lcem_pkg::EV_RST;
         state_r.umask   <= lcem_pkg::UM_RST;
         state_r.enable  <= 1'b0;
         state_r.count   <= '0;
         state_r.prdata  <= '0;
         state_r.pready  <= 1'b0;
         state_r.pslverr <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign prdata        = state_r.prdata;
   assign pready        = state_r.pready;
   assign pslverr       = state_r.pslverr;
   assign creditGrant   = grantInt;
   assign reservedEmpty = emptyInt;

endmodule : lcem_monitor

`default_nettype wire

// ### tb/lcem_chk.sv
`default_nettype none

module lcem_chk (
   // Clock and reset.
   input wire logic                           ref_clk,
   input wire logic                           sys_rst,
   // Register bus.
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic [31:0]                    prdata,
   input wire logic                           pready,
   input wire logic                           pslverr,
   // Credit interface.
   input wire lcem_pkg::lcem_req_s            creditReq,
   input wire lcem_pkg::lcem_grant_s          creditGrant,
   input wire logic [lcem_pkg::CLASS_N-1:0]   reservedEmpty
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      psel && penable && pready;
   endsequence

   AST_APB_ANSWER: assert property (s_setup |=> s_answer)
      else $error("no answer one cycle after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response without ready or with data");
   AST_GRANT_NEXT: assert property (
         creditReq.valid |=> creditGrant.valid && creditGrant.cls == $past(creditReq.cls))
      else $error("grant missing or wrong class after offer");
   AST_NO_OFFER: assert property (!creditReq.valid |=> !creditGrant.valid)
      else $error("grant without an offer");
   AST_FREE_SHARED: assert property (
         creditReq.valid && creditReq.flits == 4'h0
         |=> creditGrant.granted && !creditGrant.reserved)
      else $error("zero flit offer not taken from shared pool");
   AST_RES_CLASS: assert property (
         creditGrant.reserved |-> creditGrant.granted && creditGrant.cls < 3'h6)
      else $error("reserved grant of unknown class");
   AST_EMPTY_RISE: assert property (
         |(reservedEmpty & ~$past(reservedEmpty)) |-> creditGrant.reserved)
      else $error("reserved pool emptied without reserved grant");
endmodule : lcem_chk

bind lcem_monitor lcem_chk i_chk (.ref_clk, .sys_rst, .psel, .penable, .prdata, .pready,
   .pslverr, .creditReq, .creditGrant, .reservedEmpty);

`default_nettype wire

// ### tb/lcem_link_model.sv
`default_nettype none

module lcem_link_model (
   // Clock and reset.
   input  wire logic                           ref_clk,
   input  wire logic                           sys_rst,
   // Pacing from the bench.
   input  wire logic                           run,
   input  wire logic                           hold,
   // Link side of the monitor.
   input  wire lcem_pkg::lcem_grant_s          creditGrant,
   output var  lcem_pkg::lcem_req_s            creditReq,
   output var  lcem_pkg::lcem_ret_s            sharedRet,
   output var  logic [lcem_pkg::CLASS_N-1:0]   reservedRet
);
   timeunit 1ns;
   timeprecision 1ps;
   int                    shOut;
   int                    resOut [6];
   int                    n;
   logic [3:0]            lastFl;
   logic [5:0]            rr;
   lcem_pkg::lcem_req_s   r;

   initial {creditReq, sharedRet, reservedRet} = '0;
   // Only credits actually held are returned, since the pool does not saturate.
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shOut = 0;
         resOut = '{default: 0};
         creditReq <= '0;
         sharedRet <= '0;
         reservedRet <= '0;
      end else begin
         if (creditGrant.valid && creditGrant.granted) begin
            if (creditGrant.reserved) resOut[creditGrant.cls]++;
            else shOut += int'(lastFl);
         end
         lastFl <= creditReq.flits;
         r = 8'($urandom);
         r.valid = run && $urandom_range(2) != 0;
         creditReq <= r;
         n = (hold || shOut == 0) ? 0 : $urandom_range(shOut > 20 ? 20 : shOut, 1);
         shOut -= n;
         sharedRet <= {n != 0, n != 0 ? 7'(n) : 7'($urandom)};
         for (int c = 0; c < 6; c++) begin
            rr[c] = !hold && resOut[c] > 0 && $urandom_range(1) == 1;
            resOut[c] -= int'(rr[c]);
         end
         reservedRet <= rr;
      end
   end
endmodule : lcem_link_model

`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NT = 21;
   localparam logic [15:0] TV [NT] = '{16'h3f5c, 16'h085c, 16'h315c, 16'h3f5e, 16'h015e,
      16'h205e, 16'h0161, 16'h0261, 16'h0461, 16'h0861, 16'h1061, 16'h2061, 16'h4061,
      16'h7f61, 16'hff7d, 16'h117d, 16'h077e, 16'h707e, 16'h877e, 16'hf77e, 16'hff33};
   logic                  ref_clk = 1'b0;
   logic                  sys_rst = 1'b1;
   logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]           paddr = 12'h0;
   logic [31:0]           pwdata = 32'h0, prdata, cfgR;
   logic                  pready, pslverr, run = 1'b0, hold = 1'b0;
   lcem_pkg::lcem_req_s   creditReq;
   lcem_pkg::lcem_ret_s   sharedRet;
   lcem_pkg::lcem_grant_s creditGrant, gM;
   logic [5:0]            reservedRet, reservedEmpty, empM;
   lcem_pkg::lcem_wbocc_s wbOcc = '0;
   logic [7:0]            wbPending = 8'h0;
   logic [6:0]            prefetchEv = 7'h0;
   logic [47:0]           cntM;
   int                    shM, n_errors = 0, checks_done = 0;
   int                    resM [6];

   always #4 ref_clk = ~ref_clk;

   lcem_monitor i_dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .creditReq, .sharedRet, .reservedRet, .creditGrant, .reservedEmpty,
      .wbOcc, .wbPending, .prefetchEv);
   lcem_link_model i_link (.ref_clk, .sys_rst, .run, .hold, .creditGrant, .creditReq,
      .sharedRet, .reservedRet);

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // The request stands until the edge at which ready is sampled high.
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(64'({e, r}), 64'(x));
   endtask : rdchk

   function automatic logic hit();
      logic [5:0] r, l;
      logic       ht;
      ht = 1'b0;
      for (int v = 0; v < 2; v++) begin
         r = wbOcc.rtOcc[v];
         l = wbOcc.localOcc[v];
         ht |= (cfgR[8+4*v] && r > l || cfgR[9+4*v] && r == l || cfgR[10+4*v] && r < l)
               && (!cfgR[15] || r != 6'h0 && l != 6'h0);
      end
      case (cfgR[7:0])
         lcem_pkg::EV_RES_USE:   return gM.reserved && cfgR[8+gM.cls];
         lcem_pkg::EV_RES_EMPTY: return |(empM & cfgR[13:8]);
         lcem_pkg::EV_PREFETCH:  return |(prefetchEv & cfgR[14:8]);
         lcem_pkg::EV_WB_PEND:   return |(wbPending & cfgR[15:8]);
         lcem_pkg::EV_WB_CMP:    return ht;
         default:                return 1'b0;
      endcase
   endfunction : hit

   // Reference pool and counter; the enable is registered, so a disabling write still counts.
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shM = int'(lcem_pkg::SHARED_RST);
         resM = '{default: int'(lcem_pkg::RES_RST)};
         {empM, gM, cntM, cfgR} = '0;
      end else begin
         if (cfgR[22] && hit()) cntM++;
         // A write lands at the edge that completes its access phase.
         if (psel && penable && pready && pwrite) begin
            if (paddr == lcem_pkg::OFF_CTRL) begin
               cfgR = pwdata & 32'h0040ffff;
               if (pwdata[17]) cntM = '0;
            end
            if (paddr == lcem_pkg::OFF_CNT_LO) cntM[31:0] = pwdata;
            if (paddr == lcem_pkg::OFF_CNT_HI) cntM[47:32] = pwdata[15:0];
         end
         if (sharedRet.valid) shM += int'(sharedRet.count);
         for (int c = 0; c < 6; c++) resM[c] += int'(reservedRet[c]);
         gM = '0;
         if (creditReq.valid) begin
            gM.valid = 1'b1;
            gM.cls = creditReq.cls;
            if (int'(creditReq.flits) <= shM) begin
               shM -= int'(creditReq.flits);
               gM.granted = 1'b1;
            end else if (creditReq.cls < 3'h6 && resM[creditReq.cls] > 0) begin
               resM[creditReq.cls]--;
               {gM.granted, gM.reserved} = 2'h3;
            end
         end
         for (int c = 0; c < 6; c++) empM[c] = resM[c] == 0;
      end
   end

   always @(posedge ref_clk) begin
      prefetchEv <= 7'($urandom);
      wbPending <= 8'($urandom);
      wbOcc <= lcem_pkg::lcem_wbocc_s'(24'($urandom) & 24'h0c30c3);
   end

   always @(negedge ref_clk) begin
      if (!sys_rst) begin
         check(64'(creditGrant), 64'(gM));
         check(64'(reservedEmpty), 64'(empM));
      end
   end

   initial begin
      logic [31:0] r;
      logic        e;
      void'($urandom(96845));
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdchk(lcem_pkg::OFF_CTRL, 32'h0);
      rdchk(lcem_pkg::OFF_STATUS, 32'h4000);
      apb(1'b1, 12'h010, 32'hffffffff, r, e);
      apb(1'b0, 12'h010, 32'h0, r, e);
      check(64'({e, r}), 64'h1_0000_0000);
      for (int k = 0; k < NT; k++) begin
         hold <= k[0];
         run <= 1'b1;
         apb(1'b1, lcem_pkg::OFF_CTRL, {16'h0042, TV[k]}, r, e);
         rdchk(lcem_pkg::OFF_CTRL, {16'h0040, TV[k]});
         repeat (150) @(posedge ref_clk);
         run <= 1'b0;
         hold <= 1'b1;
         apb(1'b1, lcem_pkg::OFF_CTRL, 32'h0, r, e);
         // Let the reference take the committing edge before its count is read.
         @(posedge ref_clk);
         rdchk(lcem_pkg::OFF_CNT_LO, cntM[31:0]);
         rdchk(lcem_pkg::OFF_CNT_HI, {16'h0, cntM[47:32]});
         rdchk(lcem_pkg::OFF_STATUS, {17'h0, 7'(shM), 2'h0, empM});
      end
      apb(1'b1, lcem_pkg::OFF_CNT_HI, 32'hffff_a5c3, r, e);
      apb(1'b1, lcem_pkg::OFF_CNT_LO, 32'($urandom), r, e);
      @(posedge ref_clk);
      rdchk(lcem_pkg::OFF_CNT_LO, cntM[31:0]);
      rdchk(lcem_pkg::OFF_CNT_HI, {16'h0, cntM[47:32]});
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdchk(lcem_pkg::OFF_STATUS, 32'h4000);
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      end_sim();
   end
endmodule : tb_top

`default_nettype wire
